// [ivtu_checker.sv]
`timescale 1ns/1ps
module ivtu_checker (
	input wire logic        clk_sys,              // clock
	input wire logic        rst_n,                // reset
	input wire logic        tfr_wr,               // flag write
	input wire logic [7:0]  tfr_wdata,            // flag data
	input wire logic        sw_reset_req,         // sw reset
	input wire logic        wdog_ovf,             // watchdog
	input wire logic [3:0]  trap_a_evt,           // class a
	input wire logic [3:0]  trap_b_evt,           // class b
	input wire logic        vec_valid,            // offer
	input wire logic [23:0] vec_addr,             // address
	input wire logic [6:0]  vec_trapnum,          // number
	input wire logic [7:0]  trap_flags,           // flags
	input wire logic [7:0]  vector_segment_reg,   // segment
	input wire logic [1:0]  vector_spacing_field, // spacing
	input wire logic        svc_in_trap           // in trap
);
	logic [6:0] a_tn;
	// lowest-numbered class a source (nmi, bit 0) wins the arbitration
	assign a_tn = trap_a_evt[0] ? 7'h02 : trap_a_evt[1] ? 7'h04 : trap_a_evt[2] ? 7'h06 : 7'h08;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	sequence s_quiet(ev);
		ev && !vec_valid && !svc_in_trap ##1 !vec_valid;
	endsequence
	a_flag_class_a: assert property (
		trap_a_evt != 4'h0 |=> (trap_flags[3:0] & $past(trap_a_evt)) == $past(trap_a_evt))
		else $error("class a flag not set");
	a_flag_class_b: assert property (
		trap_b_evt != 4'h0 |=> (trap_flags[7:4] & $past(trap_b_evt)) == $past(trap_b_evt))
		else $error("class b flag not set");
	a_flag_stays_set: assert property (
		!tfr_wr |=> (trap_flags & $past(trap_flags)) == $past(trap_flags))
		else $error("flag lost without write");
	a_flag_write_clear: assert property (
		tfr_wr && trap_a_evt == 4'h0 && trap_b_evt == 4'h0
		|=> trap_flags == ($past(trap_flags) & $past(tfr_wdata))) else $error("flag write wrong");
	a_vec_in_segment: assert property (
		$rose(vec_valid) |-> vec_addr[23:16] == vector_segment_reg)
		else $error("vector outside segment");
	a_vec_offset_spacing: assert property (
		$rose(vec_valid) |-> vec_addr[15:0] == ({9'h0, vec_trapnum} << (2 + vector_spacing_field)))
		else $error("vector offset wrong");
	a_reset_to_zero: assert property (
		s_quiet(sw_reset_req || wdog_ovf) |=> vec_valid && vec_trapnum == 7'h00 && $stable(trap_flags))
		else $error("reset source vector wrong");
	a_class_a_vector: assert property (
		s_quiet(trap_a_evt != 4'h0) |=> vec_valid && vec_trapnum == $past(a_tn, 2))
		else $error("class a vector wrong");
	a_class_b_shared: assert property (
		s_quiet(trap_b_evt != 4'h0) |=> vec_valid && vec_trapnum == 7'h0a)
		else $error("class b vector wrong");
endmodule
bind ivtu_unit ivtu_checker chk_u (.*);

// [ivtu_core_model.sv]
`timescale 1ns/1ps
module ivtu_core_model (
	input  wire logic        clk_sys,    // clock
	input  wire logic        rst_n,      // reset
	input  wire logic        vec_valid,  // offer
	input  wire logic [23:0] vec_addr,   // address
	input  wire logic [6:0]  vec_trapnum,// number
	input  wire logic [3:0]  ack_delay,  // stall cycles
	output logic             vec_ack,    // take
	output logic [23:0]      taken_addr, // last branch
	output logic [6:0]       taken_tn,   // last number
	output logic [7:0]       taken_cnt   // branches
);
	logic [3:0] wait_q;
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			{wait_q, vec_ack, taken_addr, taken_tn, taken_cnt} <= '0;
		end else if (vec_valid && vec_ack) begin
			vec_ack <= 1'b0;
			wait_q <= 4'h0;
			taken_addr <= vec_addr;
			taken_tn <= vec_trapnum;
			taken_cnt <= taken_cnt + 8'h01;
		end else if (vec_valid) begin
			// a busy pipeline stalls before branching
			wait_q <= wait_q + 4'h1;
			vec_ack <= (wait_q >= ack_delay);
		end
	end
endmodule

// [ivtu_node.sv]
`timescale 1ns/1ps
module ivtu_node (
	input  wire logic clk_sys,   // system clock
	input  wire logic rst_n,     // async reset
	ivtu_node_if.node nd         // node control channel
);
	logic                        req_q;
	logic                        req_d;
	logic                        en_q;
	logic [ivtu_pkg::PRIO_W-1:0] prio_q;
	logic                        wr_req;

	// a peripheral pulse in the clearing cycle still lands
	assign wr_req = nd.wr ? nd.wdata[ivtu_pkg::NCTL_REQ_BIT] : (req_q & ~nd.ack);
	assign req_d  = wr_req | nd.periph_req;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			req_q  <= 1'b0;
			en_q   <= 1'b0;
			prio_q <= ivtu_pkg::LEVEL_RST;
		end else begin
			req_q <= req_d;
			if (nd.wr) begin
				en_q   <= nd.wdata[ivtu_pkg::NCTL_EN_BIT];
				prio_q <= nd.wdata[ivtu_pkg::NCTL_PRIO_LSB +: ivtu_pkg::PRIO_W];
			end
		end
	end

	assign nd.req  = req_q;
	assign nd.en   = en_q;
	assign nd.prio = prio_q;
endmodule

// [ivtu_node_if.sv]
`timescale 1ns/1ps
interface ivtu_node_if;
	logic                       periph_req;
	logic                       wr;
	logic                       ack;
	logic [ivtu_pkg::NCTL_W-1:0] wdata;
	logic                       req;
	logic                       en;
	logic [ivtu_pkg::PRIO_W-1:0] prio;

	modport node (input periph_req, input wr, input ack, input wdata,
		output req, output en, output prio);
	modport ctrl (output periph_req, output wr, output ack, output wdata,
		input req, input en, input prio);
endinterface

// [ivtu_pkg.sv]
package ivtu_pkg;

	// widths
	localparam int SEG_W    = 8;
	localparam int OFS_W    = 16;
	localparam int TN_W     = 7;
	localparam int PRIO_W   = 4;
	localparam int NCTL_W   = 8;
	localparam int SPC_W    = 2;
	localparam int FLAG_W   = 8;
	localparam int MAX_NODES = 8;

	// node control word layout
	localparam int NCTL_REQ_BIT  = 7;
	localparam int NCTL_EN_BIT   = 6;
	localparam int NCTL_PRIO_LSB = 0;

	// vector spacing: offset = trap number << (base + field)
	localparam int VEC_SHIFT_BASE = 2;

	// reset values
	localparam logic [SEG_W-1:0]  VECTOR_SEGMENT_REG_RST  = 8'h00;
	localparam logic [SPC_W-1:0]  SPACING_RST = 2'h0;
	localparam logic [FLAG_W-1:0] FLAGS_RST   = 8'h00;
	localparam logic [NCTL_W-1:0] NCTL_RST    = 8'h00;
	localparam logic [PRIO_W-1:0] LEVEL_RST   = 4'h0;

	// trap numbers
	localparam logic [TN_W-1:0] TN_RESET     = 7'h00;
	localparam logic [TN_W-1:0] TN_NMI       = 7'h02;
	localparam logic [TN_W-1:0] TN_STACK_OVR = 7'h04;
	localparam logic [TN_W-1:0] TN_STACK_UND = 7'h06;
	localparam logic [TN_W-1:0] TN_SOFT_BRK  = 7'h08;
	localparam logic [TN_W-1:0] TN_CLASS_B   = 7'h0a;
	localparam logic [TN_W-1:0] TN_XFER_END  = 7'h4c;

	// trap flag bit positions; class a in [3:0], class b in [7:4]
	localparam int FLG_NMI       = 0;
	localparam int FLG_STACK_OVR = 1;
	localparam int FLG_STACK_UND = 2;
	localparam int FLG_SOFT_BRK  = 3;
	localparam int FLG_BAD_OPC   = 4;
	localparam int FLG_PMEM_ERR  = 5;
	localparam int FLG_PROT_FLT  = 6;
	localparam int FLG_BAD_WORD  = 7;

	// trap number of each interrupt node slot
	localparam logic [TN_W-1:0] NODE_TN [MAX_NODES] = '{
		7'h18, 7'h2a, 7'h2b, 7'h4c, 7'h10, 7'h11, 7'h12, 7'h13
	};

	typedef enum logic [1:0] {SVC_NONE, SVC_INT, SVC_TRAPB, SVC_TRAPA} ivtu_svc_t;
	typedef enum logic [2:0] {SRC_RST, SRC_A, SRC_B, SRC_SW, SRC_INT} ivtu_src_t;

endpackage

// [ivtu_unit.sv]
// Function
// - vectors lie in software-selected segment
// - spacing field sets vector distance, default four
// - hardware traps unmaskable, class a traps branch to own vector
// - each hardware trap sets its own flag bit
// - trap preempts unless a trap of the same or higher class is active
// - trap service blocks standard and transfer interrupts
// - resets and watchdog vector zero, no flag
// - class a traps have separate vectors
// - class b traps share one vector
// - software trap reaches any number to 7f
// - transfer end node uses trap 4c
// - node control: request, enable, sixteen levels
// - accepted service interrupted only by higher level
// - software sets node request to raise it
`timescale 1ns/1ps
module ivtu_unit #(
	parameter int NODES = 8
) (
	input  wire logic                                clk_sys,        // system clock
	input  wire logic                                rst_n,          // async reset
	input  wire logic                                vector_segment_reg_wr,      // load segment
	input  wire logic [ivtu_pkg::SEG_W-1:0]          vector_segment_reg_wdata,   // new segment
	input  wire logic                                spacing_wr,     // load spacing field
	input  wire logic [ivtu_pkg::SPC_W-1:0]          spacing_wdata,  // new spacing
	input  wire logic                                tfr_wr,         // write trap flags
	input  wire logic [ivtu_pkg::FLAG_W-1:0]         tfr_wdata,      // zero bits clear flags
	input  wire logic                                node_wr,        // write node control
	input  wire logic [$clog2(NODES)-1:0]            node_sel,       // node index
	input  wire logic [ivtu_pkg::NCTL_W-1:0]         node_wdata,     // req, en, level
	input  wire logic [NODES-1:0]                    periph_req,     // peripheral pulses
	input  wire logic                                sw_reset_req,   // software reset
	input  wire logic                                wdog_ovf,       // watchdog overflow
	input  wire logic [3:0]                          trap_a_evt,     // nmi, sovr, sund, brk
	input  wire logic [3:0]                          trap_b_evt,     // opc, pmem, prot, word
	input  wire logic                                swtrap_req,     // trap instruction
	input  wire logic [ivtu_pkg::TN_W-1:0]           swtrap_num,     // its trap number
	input  wire logic                                vec_ack,        // core takes vector
	input  wire logic                                svc_return,     // service finished
	output logic                                     vec_valid,      // vector offered
	output logic [ivtu_pkg::SEG_W+ivtu_pkg::OFS_W-1:0] vec_addr,     // segment and offset
	output logic [ivtu_pkg::TN_W-1:0]                vec_trapnum,    // trap number
	output logic [ivtu_pkg::FLAG_W-1:0]              trap_flags,     // trap flag register
	output logic [ivtu_pkg::SEG_W-1:0]               vector_segment_reg,   // segment
	output logic [ivtu_pkg::SPC_W-1:0]               vector_spacing_field, // spacing
	output logic [ivtu_pkg::PRIO_W-1:0]              svc_level,      // running level
	output logic                                     svc_in_trap     // trap service runs
);
	localparam int IW = $clog2(NODES);

	logic [ivtu_pkg::SEG_W-1:0]  seg_q;
	logic [ivtu_pkg::SPC_W-1:0]  spc_q;
	logic [ivtu_pkg::FLAG_W-1:0] flags_q;
	logic [ivtu_pkg::FLAG_W-1:0] flags_d;
	logic [3:0]                  pend_a_q;
	logic                        pend_b_q;
	logic                        pend_rst_q;
	logic                        vld_q;
	logic [ivtu_pkg::SEG_W+ivtu_pkg::OFS_W-1:0] addr_q;
	logic [ivtu_pkg::TN_W-1:0]   tn_q;
	ivtu_pkg::ivtu_src_t         src_q;
	logic [1:0]                  aidx_q;
	logic [IW-1:0]               nidx_q;
	ivtu_pkg::ivtu_svc_t         newkind_q;
	logic [ivtu_pkg::PRIO_W-1:0] newlvl_q;
	ivtu_pkg::ivtu_svc_t         kind_q;
	logic [ivtu_pkg::PRIO_W-1:0] lvl_q;
	ivtu_pkg::ivtu_svc_t         save_kind_q;
	logic [ivtu_pkg::PRIO_W-1:0] save_lvl_q;
	logic                        in_trap_q;

	logic [NODES-1:0]            n_req;
	logic [NODES-1:0]            n_en;
	logic [ivtu_pkg::PRIO_W-1:0] n_prio [NODES];
	logic [NODES-1:0]            n_ack;

	ivtu_node_if nif [NODES] ();

	genvar g;
	generate
		for (g = 0; g < NODES; g++) begin : g_node
			assign nif[g].periph_req = periph_req[g];
			assign nif[g].wr         = node_wr && (node_sel == IW'(g));
			assign nif[g].wdata      = node_wdata;
			assign nif[g].ack        = n_ack[g];
			assign n_req[g]          = nif[g].req;
			assign n_en[g]           = nif[g].en;
			assign n_prio[g]         = nif[g].prio;
			ivtu_node u_node (
				.clk_sys (clk_sys),
				.rst_n   (rst_n),
				.nd      (nif[g])
			);
		end
	endgenerate

	// best enabled node; level 0 never wins, as usual for disabled priority
	logic                        int_hit;
	logic [IW-1:0]               int_idx;
	logic [ivtu_pkg::PRIO_W-1:0] int_prio;
	always_comb begin
		int_hit  = 1'b0;
		int_idx  = '0;
		int_prio = '0;
		for (int i = 0; i < NODES; i++) begin
			if (n_req[i] && n_en[i] && (n_prio[i] > int_prio)) begin
				int_hit  = 1'b1;
				int_idx  = IW'(i);
				int_prio = n_prio[i];
			end
		end
	end

	// class a order: nmi first
	wire [1:0] a_idx = pend_a_q[0] ? 2'h0 : pend_a_q[1] ? 2'h1 : pend_a_q[2] ? 2'h2 : 2'h3;
	wire [ivtu_pkg::TN_W-1:0] a_tn =
		(a_idx == 2'h0) ? ivtu_pkg::TN_NMI :
		(a_idx == 2'h1) ? ivtu_pkg::TN_STACK_OVR :
		(a_idx == 2'h2) ? ivtu_pkg::TN_STACK_UND : ivtu_pkg::TN_SOFT_BRK;

	// a trap waits only behind a trap of the same or a higher class; no mask applies
	wire take_a   = |pend_a_q && (kind_q != ivtu_pkg::SVC_TRAPA);
	wire take_b   = pend_b_q && (kind_q < ivtu_pkg::SVC_TRAPB);
	wire in_trap  = (kind_q == ivtu_pkg::SVC_TRAPA) || (kind_q == ivtu_pkg::SVC_TRAPB);
	wire take_int = int_hit && !in_trap &&
		((kind_q == ivtu_pkg::SVC_NONE) || (int_prio > lvl_q));

	logic                        sel_v;
	ivtu_pkg::ivtu_src_t         sel_src;
	logic [ivtu_pkg::TN_W-1:0]   sel_tn;
	ivtu_pkg::ivtu_svc_t         sel_kind;
	logic [ivtu_pkg::PRIO_W-1:0] sel_lvl;
	always_comb begin
		sel_v    = 1'b1;
		sel_src  = ivtu_pkg::SRC_RST;
		sel_tn   = ivtu_pkg::TN_RESET;
		sel_kind = ivtu_pkg::SVC_NONE;
		sel_lvl  = ivtu_pkg::LEVEL_RST;
		if (pend_rst_q) begin
			sel_src = ivtu_pkg::SRC_RST;
		end else if (take_a) begin
			sel_src  = ivtu_pkg::SRC_A;
			sel_tn   = a_tn;
			sel_kind = ivtu_pkg::SVC_TRAPA;
			sel_lvl  = lvl_q;
		end else if (take_b) begin
			sel_src  = ivtu_pkg::SRC_B;
			sel_tn   = ivtu_pkg::TN_CLASS_B;
			sel_kind = ivtu_pkg::SVC_TRAPB;
			sel_lvl  = lvl_q;
		end else if (swtrap_req) begin
			sel_src  = ivtu_pkg::SRC_SW;
			sel_tn   = swtrap_num;
			sel_kind = kind_q;
			sel_lvl  = lvl_q;
		end else if (take_int) begin
			sel_src  = ivtu_pkg::SRC_INT;
			sel_tn   = ivtu_pkg::NODE_TN[int_idx];
			sel_kind = ivtu_pkg::SVC_INT;
			sel_lvl  = int_prio;
		end else begin
			sel_v = 1'b0;
		end
	end

	// offset is the trap number scaled by the spacing field
	wire [ivtu_pkg::OFS_W-1:0] sel_ofs =
		{{(ivtu_pkg::OFS_W-ivtu_pkg::TN_W){1'b0}}, sel_tn} << (ivtu_pkg::VEC_SHIFT_BASE + spc_q);
	wire offer = sel_v && !vld_q;
	wire taken = vld_q && vec_ack;

	// the node is cleared only once the core has taken its vector
	generate
		for (g = 0; g < NODES; g++) begin : g_ack
			assign n_ack[g] = taken && (src_q == ivtu_pkg::SRC_INT) && (nidx_q == IW'(g));
		end
	endgenerate

	// set wins over the software clear in the same cycle
	wire [ivtu_pkg::FLAG_W-1:0] flag_set = {trap_b_evt, trap_a_evt};
	assign flags_d = (tfr_wr ? (flags_q & tfr_wdata) : flags_q) | flag_set;

	wire [3:0] a_clr = (taken && src_q == ivtu_pkg::SRC_A) ? (4'h1 << aidx_q) : 4'h0;
	wire       b_clr = taken && (src_q == ivtu_pkg::SRC_B);
	wire       r_clr = taken && (src_q == ivtu_pkg::SRC_RST);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			seg_q   <= ivtu_pkg::VECTOR_SEGMENT_REG_RST;
			spc_q   <= ivtu_pkg::SPACING_RST;
			flags_q <= ivtu_pkg::FLAGS_RST;
		end else begin
			if (vector_segment_reg_wr) begin
				seg_q <= vector_segment_reg_wdata;
			end
			if (spacing_wr) begin
				spc_q <= spacing_wdata;
			end
			flags_q <= flags_d;
		end
	end

	// pending requests; the reset sources never touch the flags
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pend_a_q   <= 4'h0;
			pend_b_q   <= 1'b0;
			pend_rst_q <= 1'b0;
		end else begin
			pend_a_q   <= (pend_a_q & ~a_clr) | trap_a_evt;
			pend_b_q   <= (pend_b_q & ~b_clr) | (|trap_b_evt);
			pend_rst_q <= (pend_rst_q & ~r_clr) | sw_reset_req | wdog_ovf;
		end
	end

	// offered vector holds until the core takes it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			vld_q     <= 1'b0;
			addr_q    <= '0;
			tn_q      <= ivtu_pkg::TN_RESET;
			src_q     <= ivtu_pkg::SRC_RST;
			aidx_q    <= 2'h0;
			nidx_q    <= '0;
			newkind_q <= ivtu_pkg::SVC_NONE;
			newlvl_q  <= ivtu_pkg::LEVEL_RST;
		end else if (offer) begin
			vld_q     <= 1'b1;
			addr_q    <= {seg_q, sel_ofs};
			tn_q      <= sel_tn;
			src_q     <= sel_src;
			aidx_q    <= a_idx;
			nidx_q    <= int_idx;
			newkind_q <= sel_kind;
			newlvl_q  <= sel_lvl;
		end else if (taken) begin
			vld_q <= 1'b0;
		end
	end

	// one level of nesting is kept; a return restores the interrupted service
	// in_trap_q mirrors kind_q so the trap status leaves the block from a flop
	wire new_in_trap  = (newkind_q == ivtu_pkg::SVC_TRAPA) ||
		(newkind_q == ivtu_pkg::SVC_TRAPB);
	wire save_in_trap = (save_kind_q == ivtu_pkg::SVC_TRAPA) ||
		(save_kind_q == ivtu_pkg::SVC_TRAPB);
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			kind_q      <= ivtu_pkg::SVC_NONE;
			lvl_q       <= ivtu_pkg::LEVEL_RST;
			save_kind_q <= ivtu_pkg::SVC_NONE;
			save_lvl_q  <= ivtu_pkg::LEVEL_RST;
			in_trap_q   <= 1'b0;
		end else if (taken && src_q == ivtu_pkg::SRC_RST) begin
			kind_q      <= ivtu_pkg::SVC_NONE;
			lvl_q       <= ivtu_pkg::LEVEL_RST;
			save_kind_q <= ivtu_pkg::SVC_NONE;
			save_lvl_q  <= ivtu_pkg::LEVEL_RST;
			in_trap_q   <= 1'b0;
		end else if (taken) begin
			kind_q      <= newkind_q;
			lvl_q       <= newlvl_q;
			save_kind_q <= kind_q;
			save_lvl_q  <= lvl_q;
			in_trap_q   <= new_in_trap;
		end else if (svc_return) begin
			kind_q      <= save_kind_q;
			lvl_q       <= save_lvl_q;
			save_kind_q <= ivtu_pkg::SVC_NONE;
			save_lvl_q  <= ivtu_pkg::LEVEL_RST;
			in_trap_q   <= save_in_trap;
		end
	end

	assign vec_valid            = vld_q;
	assign vec_addr             = addr_q;
	assign vec_trapnum          = tn_q;
	assign trap_flags           = flags_q;
	assign vector_segment_reg   = seg_q;
	assign vector_spacing_field = spc_q;
	assign svc_level            = lvl_q;
	assign svc_in_trap          = in_trap_q;
endmodule

// [ivtu_unit_bench.sv]
`timescale 1ns/1ps
module ivtu_unit_bench;
	localparam int EV_A = 0, EV_B = 1, EV_SRST = 2, EV_WDOG = 3, EV_PER = 4, EV_TFR = 5;
	localparam int EV_SEG = 6, EV_SPC = 7, EV_NODE = 8, EV_RET = 9;
	logic        clk_sys, rst_n, vector_segment_reg_wr, spacing_wr, tfr_wr, node_wr;
	logic        sw_reset_req, wdog_ovf, swtrap_req, vec_ack, svc_return, vec_valid, svc_in_trap;
	logic [7:0]  vector_segment_reg_wdata, tfr_wdata, node_wdata, periph_req, trap_flags, vector_segment_reg;
	logic [7:0]  taken_cnt, seen_cnt;
	logic [1:0]  spacing_wdata, vector_spacing_field;
	logic [2:0]  node_sel;
	logic [3:0]  trap_a_evt, trap_b_evt, svc_level, ack_delay;
	logic [6:0]  swtrap_num, vec_trapnum, taken_tn;
	logic [23:0] vec_addr, taken_addr;
	int          n_mismatch, comparisons, cycles, i;

	ivtu_unit #(.NODES(8)) dut_u (.*);
	ivtu_core_model core_u (.clk_sys(clk_sys), .rst_n(rst_n), .vec_valid(vec_valid),
		.vec_addr(vec_addr), .vec_trapnum(vec_trapnum), .ack_delay(ack_delay), .vec_ack(vec_ack),
		.taken_addr(taken_addr), .taken_tn(taken_tn), .taken_cnt(taken_cnt));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic end_sim;
		$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			n_mismatch++;
			end_sim();
		end
	end

	task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one-cycle pulse on the chosen input, all pulses cleared together
	task automatic ev(input int k, input logic [10:0] v);
		@(negedge clk_sys);
		case (k)
			EV_A: trap_a_evt = v[3:0];
			EV_B: trap_b_evt = v[3:0];
			EV_SRST: sw_reset_req = 1'b1;
			EV_WDOG: wdog_ovf = 1'b1;
			EV_PER: periph_req = v[7:0];
			EV_TFR: {tfr_wr, tfr_wdata} = {1'b1, v[7:0]};
			EV_SEG: {vector_segment_reg_wr, vector_segment_reg_wdata} = {1'b1, v[7:0]};
			EV_SPC: {spacing_wr, spacing_wdata} = {1'b1, v[1:0]};
			EV_NODE: {node_wr, node_sel, node_wdata} = {1'b1, v};
			default: svc_return = 1'b1;
		endcase
		@(negedge clk_sys);
		{trap_a_evt, trap_b_evt, sw_reset_req, wdog_ovf, periph_req, tfr_wr} = '0;
		{vector_segment_reg_wr, spacing_wr, node_wr, svc_return} = '0;
	endtask

	// the trap instruction stays asserted until its vector is offered
	task automatic sw(input logic [6:0] n);
		int j;
		j = 0;
		@(negedge clk_sys);
		{swtrap_req, swtrap_num} = {1'b1, n};
		while (vec_valid !== 1'b1 && j < 20) begin
			@(negedge clk_sys);
			j++;
		end
		swtrap_req = 1'b0;
	endtask

	task automatic exp_vec(input logic [6:0] tn, input logic [15:0] ofs);
		int j;
		j = 0;
		while (taken_cnt === seen_cnt && j < 40) begin
			@(negedge clk_sys);
			j++;
		end
		seen_cnt = taken_cnt;
		chk("vector taken", {23'h0, j < 40}, 24'h1);
		chk("vec_trapnum", {17'h0, taken_tn}, {17'h0, tn});
		chk("vec_addr", taken_addr, {8'h3c, ofs});
	endtask

	task automatic no_vec(input int n);
		repeat (n) @(negedge clk_sys);
		chk("no vector", {16'h0, taken_cnt}, {16'h0, seen_cnt});
	endtask

	initial begin
		{vector_segment_reg_wr, spacing_wr, tfr_wr, node_wr, sw_reset_req, wdog_ovf, swtrap_req} = '0;
		{vector_segment_reg_wdata, tfr_wdata, node_wdata, periph_req, spacing_wdata, node_sel} = '0;
		{trap_a_evt, trap_b_evt, swtrap_num, svc_return, ack_delay, seen_cnt} = '0;
		rst_n = 1'b0;
		repeat (8) @(negedge clk_sys);
		rst_n = 1'b1;
		chk("reset state", {trap_flags, vector_segment_reg, 6'h0, vector_spacing_field}, 24'h0);
		ev(EV_SEG, 11'h03c);
		for (i = 0; i < 4; i++) begin
			ev(EV_A, 11'(1 << i));
			exp_vec(7'(2 + 2 * i), 16'(8 * (i + 1)));
			ev(EV_RET, 11'h0);
		end
		chk("trap_flags", {16'h0, trap_flags}, 24'h00000f);
		ack_delay = 4'h5;
		for (i = 0; i < 4; i++) begin
			ev(EV_B, 11'(1 << i));
			exp_vec(7'h0a, 16'h0028);
			ev(EV_RET, 11'h0);
		end
		chk("trap_flags", {16'h0, trap_flags}, 24'h0000ff);
		ev(EV_TFR, 11'h00f);
		chk("trap_flags", {16'h0, trap_flags}, 24'h00000f);
		ev(EV_SRST, 11'h0);
		exp_vec(7'h00, 16'h0000);
		ev(EV_WDOG, 11'h0);
		exp_vec(7'h00, 16'h0000);
		chk("trap_flags", {16'h0, trap_flags}, 24'h00000f);
		ev(EV_TFR, 11'h000);
		chk("trap_flags", {16'h0, trap_flags}, 24'h000000);
		ack_delay = 4'h0;
		ev(EV_SPC, 11'h001);
		sw(7'h7f);
		exp_vec(7'h7f, 16'h03f8);
		ev(EV_RET, 11'h0);
		ev(EV_SPC, 11'h000);
		sw(7'h7f);
		exp_vec(7'h7f, 16'h01fc);
		ev(EV_RET, 11'h0);
		sw(7'h00);
		exp_vec(7'h00, 16'h0000);
		ev(EV_RET, 11'h0);
		ev(EV_NODE, {3'h3, 8'hc5});
		exp_vec(7'h4c, 16'h0130);
		chk("svc_level", {20'h0, svc_level}, 24'h5);
		ev(EV_NODE, {3'h4, 8'hc3});
		no_vec(6);
		ev(EV_RET, 11'h0);
		exp_vec(7'h10, 16'h0040);
		ev(EV_RET, 11'h0);
		ev(EV_NODE, {3'h5, 8'h85});
		no_vec(4);
		ev(EV_NODE, {3'h0, 8'h4f});
		ev(EV_A, 11'h002);
		exp_vec(7'h04, 16'h0010);
		chk("svc_in_trap", {23'h0, svc_in_trap}, 24'h1);
		ev(EV_PER, 11'h001);
		no_vec(6);
		ev(EV_B, 11'h001);
		no_vec(6);
		ev(EV_RET, 11'h0);
		exp_vec(7'h0a, 16'h0028);
		ev(EV_A, 11'h001);
		exp_vec(7'h02, 16'h0008);
		ev(EV_RET, 11'h0);
		no_vec(4);
		ev(EV_RET, 11'h0);
		exp_vec(7'h18, 16'h0060);
		ev(EV_RET, 11'h0);
		end_sim();
	end
endmodule
